// file: rtl/rfdt_map.svh
// register map, field positions, reset values and timing counts of the
// rf driver timing and threshold register bank
// assumes byte-addressed wishbone access, one register per aligned 32-bit word
`ifndef RFDT_MAP_SVH
`define RFDT_MAP_SVH

// printed register indices; byte address is four times the word index
`define RFDT_OFS_AUX_MOD      10'h028
`define RFDT_OFS_TX_TIMING    10'h029
`define RFDT_OFS_ACT_THR      10'h02a
`define RFDT_OFS_RESISTIVE_MODULATION_ENABLE       10'h02a
`define RFDT_OFS_TIMING_RD    10'h02b
// word index bit that selects register space b
`define RFDT_SPACE_B          10'h100

// driver timing register fields
`define RFDT_TIM_TARGET_MSB   7
`define RFDT_TIM_TARGET_LSB   4
`define RFDT_TIM_MAN_BIT      3
`define RFDT_TIM_CODE_MSB     2
// resistive am register fields
`define RFDT_RAM_FORCE_BIT    7
`define RFDT_RAM_LEVEL_MSB    6
// activation threshold fields
`define RFDT_THR_PEER_MSB     6
`define RFDT_THR_PEER_LSB     4
`define RFDT_THR_CA_MSB       3
// auxiliary modulation field
`define RFDT_AUX_RESISTIVE_MODULATION_ENABLE_BIT   3

// reset values
`define RFDT_RST_TX_TIMING    8'h7c
`define RFDT_RST_ACT_THR      8'h33
`define RFDT_RST_RESISTIVE_MODULATION_ENABLE       8'h00
`define RFDT_RST_AUX_MOD      8'h00
// writable bits
`define RFDT_WMASK_ACT_THR    8'h7f
`define RFDT_WMASK_AUX_MOD    8'h08

// timing codes
`define RFDT_CODE_SLOW        3'h0
`define RFDT_CODE_FAST        3'h4

// calibration budget
`define RFDT_CAL_STEPS        5
`define RFDT_CAL_MAX_PERIODS  10
// clock cycles per rf period; one dwell must cover the driver flop, the
// analog answer and the two-stage synchroniser before the compare
`define RFDT_RF_PERIOD_CYC    2

`endif

// file: rtl/rfdt_pkg.sv
// types shared by the rf driver timing register bank and its calibrator
// assumes the constants of rfdt_map.svh
package rfdt_pkg;

    // calibration sequencer states
    typedef enum logic [1:0] {
        cal_idle,
        cal_measure,
        cal_hold
    } rfdt_cal_state_t;

    // settings towards the analog rf driver
    typedef struct packed {
        logic [2:0] timing_code;
        logic       min_nonoverlap_force;
        logic       resistive_modulation_enable;
        logic [6:0] resistive_mod_level;
    } rfdt_drv_t;

    // settings towards the field detector comparators
    typedef struct packed {
        logic [2:0] peer_level;
        logic [3:0] ca_level;
    } rfdt_fdet_t;

    // calibrator status
    typedef struct packed {
        logic       busy;
        logic       done;
        logic [2:0] step;
        logic [3:0] ratio;
    } rfdt_cal_t;

endpackage

// file: rtl/rfdt_cal.sv
// automatic driver transient calibration sequencer
// assumes ratio_i is already synchronised to clk_i, which runs a fixed
// number of cycles per rf carrier period
`timescale 1ns/1ps
`default_nettype none
`include "rfdt_map.svh"

module rfdt_cal #(
    parameter int STEPS  = `RFDT_CAL_STEPS,
    parameter int BUDGET = `RFDT_CAL_MAX_PERIODS * `RFDT_RF_PERIOD_CYC
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // control
    input  wire logic              tx_en_i,
    input  wire logic [3:0]        target_i,
    input  wire logic [3:0]        ratio_i,
    // status
    output rfdt_pkg::rfdt_cal_t    cal_o
);
    import rfdt_pkg::*;

    localparam int DWELL = BUDGET / STEPS;
    localparam logic [2:0] LAST = 3'(STEPS - 1);
    localparam logic [2:0] DW_END = 3'(DWELL - 1);

    // refuse settings the 3-bit code and counters cannot serve, or a dwell
    // too short to see the synchronised ratio of the current step
    if (STEPS < 2 || STEPS > 5 || DWELL < 4 || DWELL > 8 || BUDGET > 31) begin : g_bad
        $error("rfdt_cal: unsupported STEPS or BUDGET");
    end

    rfdt_cal_state_t state;
    logic            tx_en_q;
    logic [2:0]      step;
    logic [2:0]      cnt;
    logic [3:0]      ratio_q;
    logic            start;
    logic            dwell_end;

    assign start     = tx_en_i & ~tx_en_q;
    assign dwell_end = (state == cal_measure) && (cnt == DW_END);

    // transmitter enable edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) tx_en_q <= 1'b0;
        else       tx_en_q <= tx_en_i;
    end

    // step sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= cal_idle;
            step    <= `RFDT_CODE_SLOW;
            cnt     <= 3'h0;
            ratio_q <= 4'h0;
        end else if (start) begin
            state <= cal_measure;
            step  <= `RFDT_CODE_SLOW;
            cnt   <= 3'h0;
        end else begin
            case (state)
                cal_measure: begin
                    if (cnt == DW_END) begin
                        ratio_q <= ratio_i;
                        if (ratio_i >= target_i || step == LAST) begin
                            state <= cal_hold;
                        end else begin
                            step <= step + 3'h1;
                            cnt  <= 3'h0;
                        end
                    end else begin
                        cnt <= cnt + 3'h1;
                    end
                end
                cal_idle: state <= cal_idle;
                cal_hold: state <= cal_hold;
                default:  state <= cal_idle;
            endcase
        end
    end

    // status out
    assign cal_o.busy  = (state == cal_measure);
    assign cal_o.done  = (state == cal_hold);
    assign cal_o.step  = step;
    assign cal_o.ratio = ratio_q;

    // cycles spent measuring since the last start
    logic [4:0] busy_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || start) busy_cnt <= 5'h0;
        else if (state == cal_measure) busy_cnt <= busy_cnt + 5'h1;
    end

    sequence s_cal_start;
        start;
    endsequence

    a_cal_start_slow: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cal_start |=> (state == cal_measure && step == `RFDT_CODE_SLOW))
        else $error("calibration did not start at slowest step");
    a_cal_advance: assert property (@(posedge clk_i) disable iff (rst_i)
        (dwell_end && !start && ratio_i < target_i && step != LAST)
        |=> (step == $past(step) + 3'h1 && state == cal_measure))
        else $error("calibration did not advance on low ratio");
    a_cal_stop_met: assert property (@(posedge clk_i) disable iff (rst_i)
        (dwell_end && !start && ratio_i >= target_i)
        |=> (state == cal_hold && $stable(step)))
        else $error("calibration did not stop on met ratio");
    a_cal_budget: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_cnt <= 5'(BUDGET) && step <= LAST)
        else $error("calibration exceeded its budget");
    a_cal_hold_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == cal_hold && !start) |=> $stable(step))
        else $error("final step not held");

endmodule
`default_nettype wire

// file: rtl/rfdt_regs.sv
// rf driver timing, field detector threshold and resistive am register bank
// assumes a classic wishbone master on clk_i, the rf carrier clock, and
// analog measurement pins that are asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "rfdt_map.svh"

module rfdt_regs (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // transmitter control from the transceiver core
    input  wire logic              tx_en_i,
    // analog measurement of non-overlap times per rf period
    input  wire logic [3:0]        meas_ratio_i,
    // analog rf driver and field detector settings
    output rfdt_pkg::rfdt_drv_t    drv_o,
    output rfdt_pkg::rfdt_fdet_t   fdet_o,
    output logic                   cal_busy_o
);
    import rfdt_pkg::*;

    localparam logic [9:0] IDX_TIMING = `RFDT_SPACE_B | `RFDT_OFS_TX_TIMING;
    localparam logic [9:0] IDX_RESISTIVE_MODULATION_ENABLE = `RFDT_SPACE_B | `RFDT_OFS_RESISTIVE_MODULATION_ENABLE;
    localparam logic [9:0] IDX_AUX    = `RFDT_SPACE_B | `RFDT_OFS_AUX_MOD;
    localparam logic [9:0] IDX_RDOUT  = `RFDT_SPACE_B | `RFDT_OFS_TIMING_RD;
    localparam logic [9:0] IDX_THR    = `RFDT_OFS_ACT_THR;

    // register storage
    logic [7:0]  tx_driver_timing_ctrl;
    logic [7:0]  field_detect_activation_level;
    logic [7:0]  resistive_am_level;
    logic [7:0]  aux_mod_ctrl;

    // bus decode
    logic [9:0]  idx;
    logic        req;
    logic        wr;
    logic [7:0]  rd_byte;
    logic [7:0]  wr_byte;

    // measurement synchroniser
    logic [3:0]  ratio_meta;
    logic [3:0]  ratio_sync;

    // calibrator link
    rfdt_cal_t   cal;
    logic [2:0]  next_code;

    assign idx     = wb_adr_i[11:2];
    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr      = req & wb_we_i & wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    // two-stage synchroniser for the asynchronous measurement pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ratio_meta <= 4'h0;
            ratio_sync <= 4'h0;
        end else begin
            ratio_meta <= meas_ratio_i;
            ratio_sync <= ratio_meta;
        end
    end

    // automatic transient calibration
    rfdt_cal #(
        .STEPS  (`RFDT_CAL_STEPS),
        .BUDGET (`RFDT_CAL_MAX_PERIODS * `RFDT_RF_PERIOD_CYC)
    ) u_cal (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tx_en_i  (tx_en_i),
        .target_i (tx_driver_timing_ctrl[`RFDT_TIM_TARGET_MSB:`RFDT_TIM_TARGET_LSB]),
        .ratio_i  (ratio_sync),
        .cal_o    (cal)
    );

    // acknowledge one cycle after the request, drop it the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) wb_ack_o <= 1'b0;
        else       wb_ack_o <= req;
    end

    // read multiplexer; unmapped words read zero
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_TIMING: rd_byte = tx_driver_timing_ctrl;
            IDX_THR:    rd_byte = field_detect_activation_level;
            IDX_RESISTIVE_MODULATION_ENABLE: rd_byte = resistive_am_level;
            IDX_AUX:    rd_byte = aux_mod_ctrl;
            IDX_RDOUT:  rd_byte = {cal.ratio, 4'h0};
            default:    rd_byte = 8'h00;
        endcase
    end

    // read data captured with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // driver timing register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_driver_timing_ctrl <= `RFDT_RST_TX_TIMING;
        end else if (wr && idx == IDX_TIMING) begin
            tx_driver_timing_ctrl <= wr_byte;
        end
    end

    // field detector activation threshold, bit 7 stays zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            field_detect_activation_level <= `RFDT_RST_ACT_THR;
        end else if (wr && idx == IDX_THR) begin
            field_detect_activation_level <= wr_byte & `RFDT_WMASK_ACT_THR;
        end
    end

    // resistive am level and minimum non-overlap force
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resistive_am_level <= `RFDT_RST_RESISTIVE_MODULATION_ENABLE;
        end else if (wr && idx == IDX_RESISTIVE_MODULATION_ENABLE) begin
            resistive_am_level <= wr_byte;
        end
    end

    // auxiliary modulation: only the resistive am enable is held here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_mod_ctrl <= `RFDT_RST_AUX_MOD;
        end else if (wr && idx == IDX_AUX) begin
            aux_mod_ctrl <= wr_byte & `RFDT_WMASK_AUX_MOD;
        end
    end

    // timing code choice: manual field or calibrated step
    always_comb begin
        if (tx_driver_timing_ctrl[`RFDT_TIM_MAN_BIT]) begin
            if (tx_driver_timing_ctrl[`RFDT_TIM_CODE_MSB]) begin
                next_code = `RFDT_CODE_FAST;
            end else begin
                next_code = tx_driver_timing_ctrl[`RFDT_TIM_CODE_MSB:0];
            end
        end else begin
            next_code = cal.step;
        end
    end

    // registered settings towards the analog driver
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o <= '0;
        end else begin
            drv_o.timing_code                 <= next_code;
            drv_o.min_nonoverlap_force        <= resistive_am_level[`RFDT_RAM_FORCE_BIT];
            drv_o.resistive_modulation_enable <= aux_mod_ctrl[`RFDT_AUX_RESISTIVE_MODULATION_ENABLE_BIT];
            // modulated resistance only offered while resistive am is on
            if (aux_mod_ctrl[`RFDT_AUX_RESISTIVE_MODULATION_ENABLE_BIT]) begin
                drv_o.resistive_mod_level <= resistive_am_level[`RFDT_RAM_LEVEL_MSB:0];
            end else begin
                drv_o.resistive_mod_level <= 7'h00;
            end
        end
    end

    // registered settings towards the field detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fdet_o <= '0;
        end else begin
            fdet_o.peer_level <= field_detect_activation_level[`RFDT_THR_PEER_MSB:`RFDT_THR_PEER_LSB];
            fdet_o.ca_level   <= field_detect_activation_level[`RFDT_THR_CA_MSB:0];
        end
    end

    assign cal_busy_o = cal.busy;

    // bus sequences
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_req |=> s_ack_pulse)
        else $error("wishbone ack not a single cycle after request");

    a_timing_target: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == IDX_TIMING)
        |=> ##1 (u_cal.target_i == $past(wr_byte[7:4], 2)))
        else $error("calibration target not taken from upper nibble");

    a_manual_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_driver_timing_ctrl[`RFDT_TIM_MAN_BIT] == 1'b0)
        |=> (drv_o.timing_code == $past(cal.step)))
        else $error("automatic timing not routed to driver");

    a_manual_code: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_driver_timing_ctrl[3] && tx_driver_timing_ctrl[2])
        |=> (drv_o.timing_code == `RFDT_CODE_FAST))
        else $error("manual 1xx code not mapped to fast");

    a_force_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == IDX_RESISTIVE_MODULATION_ENABLE)
        |=> ##1 (drv_o.min_nonoverlap_force == $past(wr_byte[7], 2)))
        else $error("minimum non-overlap force not following bit 7");

    a_resistive_modulation_enable_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        aux_mod_ctrl[3]
        |=> (drv_o.resistive_mod_level == $past(resistive_am_level[6:0])))
        else $error("modulated resistance not taken from level field");

    a_resistive_modulation_enable_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !aux_mod_ctrl[3] |=> (drv_o.resistive_mod_level == 7'h00))
        else $error("modulated resistance offered while disabled");

    a_thr_unused: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == IDX_THR)
        |=> (field_detect_activation_level[7] == 1'b0)
            ##1 (fdet_o.ca_level == $past(wr_byte[3:0], 2)))
        else $error("threshold fields misplaced");

    a_readout: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && idx == IDX_RDOUT)
        |=> (wb_dat_o == {24'h00_0000, $past(cal.ratio), 4'h0}))
        else $error("ratio readout mismatch");

endmodule
`default_nettype wire

// file: verif/rfdt_drv_model.sv
// behavioural analog rf driver: reports non-overlap times per rf period
// assumes timing codes 0..4 from the register bank, 4 being the fastest
`timescale 1ns/1ps
`default_nettype none
module rfdt_drv_model (
    // clock and answer speed
    input  wire logic                clk_i,
    input  wire logic                slow_i,
    // driver setting from the bank
    input  wire rfdt_pkg::rfdt_drv_t drv_i,
    // measured ratio towards the bank
    output logic [3:0]               meas_ratio_o
);
    import rfdt_pkg::*;

    logic [3:0] ratio;
    logic [3:0] late;

    // each faster transient adds two non-overlap times per period
    always_comb begin
        ratio = 4'((32'(drv_i.timing_code) + 1) * 2);
    end

    // slow mode settles one clock after the code changes
    always_ff @(posedge clk_i) begin
        late <= ratio;
    end

    // prompt answer follows the code at once
    always_comb begin
        meas_ratio_o = slow_i ? late : ratio;
    end
endmodule
`default_nettype wire

// file: verif/rfdt_regs_bench.sv
// self-checking bench of the rf driver timing and threshold register bank
// assumes the analog driver model of rfdt_drv_model.sv on the far side
`timescale 1ns/1ps
`default_nettype none
`include "rfdt_map.svh"
module rfdt_regs_bench;
    import rfdt_pkg::*;

    // calibration budget in clock cycles
    localparam int CAL_CYC = `RFDT_CAL_MAX_PERIODS * `RFDT_RF_PERIOD_CYC;

    typedef struct packed {
        logic [11:0] adr;
        logic [7:0]  wdat;
        logic [7:0]  rexp;
        logic [11:0] dexp;
        logic [6:0]  fexp;
    } rfdt_row_t;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        tx_en_i;
    logic        slow;
    logic [3:0]  meas_ratio;
    logic        cal_busy_o;
    rfdt_drv_t   drv_o;
    rfdt_fdet_t  fdet_o;
    int          bad_count;
    int          num_checks;
    int          busy_n;
    logic [2:0]  first_code;
    logic [31:0] rd;
    logic [31:0] r0;
    logic [3:0]  tgts [4] = '{4'h1, 4'h5, 4'h9, 4'hb};
    logic [2:0]  codes [4] = '{3'h0, 3'h2, 3'h4, 3'h4};
    // write, read back, then driver and detector settings
    rfdt_row_t   rows [13] = '{
        '{12'h4a4, 8'h58, 8'h58, 12'h000, 7'h33},
        '{12'h4a4, 8'h59, 8'h59, 12'h200, 7'h33},
        '{12'h4a4, 8'h5a, 8'h5a, 12'h400, 7'h33},
        '{12'h4a4, 8'h5b, 8'h5b, 12'h600, 7'h33},
        '{12'h4a4, 8'h5c, 8'h5c, 12'h800, 7'h33},
        '{12'h4a4, 8'h5f, 8'h5f, 12'h800, 7'h33},
        '{12'h0a8, 8'hff, 8'h7f, 12'h800, 7'h7f}, // bit 7 masked to 0
        '{12'h0a8, 8'h48, 8'h48, 12'h800, 7'h48},
        '{12'h4a8, 8'hc5, 8'hc5, 12'h900, 7'h48},
        '{12'h4a0, 8'hff, 8'h08, 12'h9c5, 7'h48},
        '{12'h4a8, 8'h40, 8'h40, 12'h8c0, 7'h48},
        '{12'h0a4, 8'haa, 8'h00, 12'h8c0, 7'h48},
        '{12'h4a0, 8'h00, 8'h00, 12'h800, 7'h48}};

    rfdt_regs i_rfdt_regs (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .wb_cyc_i     (wb_cyc_i),
        .wb_stb_i     (wb_stb_i),
        .wb_we_i      (wb_we_i),
        .wb_adr_i     (wb_adr_i),
        .wb_sel_i     (wb_sel_i),
        .wb_dat_i     (wb_dat_i),
        .wb_dat_o     (wb_dat_o),
        .wb_ack_o     (wb_ack_o),
        .tx_en_i      (tx_en_i),
        .meas_ratio_i (meas_ratio),
        .drv_o        (drv_o),
        .fdet_o       (fdet_o),
        .cal_busy_o   (cal_busy_o)
    );

    rfdt_drv_model i_rfdt_drv_model (
        .clk_i        (clk_i),
        .slow_i       (slow),
        .drv_i        (drv_o),
        .meas_ratio_o (meas_ratio)
    );

    // 250 mhz rf carrier clock
    always #2 clk_i = ~clk_i;

    // prints the counts and the verdict, then stops
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic [11:0] adr, input logic we, input logic [7:0] d,
                      input logic s0, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= {3'h7, s0};
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            $display("wishbone answer missing at %0t", $time);
            conclude();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb(adr, 1'b1, d, 1'b1, q);
    endtask

    task automatic rdchk(input logic [11:0] adr, input logic [7:0] exp);
        wb(adr, 1'b0, 8'h00, 1'b1, rd);
        check(rd, {24'h0, exp});
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // fresh transmitter enable, then counts busy cycles and notes the first step
    task automatic cal_run();
        @(posedge clk_i);
        tx_en_i <= 1'b0;
        @(posedge clk_i);
        tx_en_i <= 1'b1;
        busy_n = 0;
        for (int n = 0; n < 30; n++) begin
            @(posedge clk_i);
            #1;
            if (cal_busy_o === 1'b1) busy_n++;
            else if (busy_n > 0) break;
            if (busy_n == 2) first_code = drv_o.timing_code;
        end
    endtask

    // main sequence
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, tx_en_i, slow} = 5'h00;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check(32'(drv_o), 32'h800);
        check(32'(fdet_o), 32'h33);
        rdchk(12'h4a4, 8'h7c);
        rdchk(12'h0a8, 8'h33);
        rdchk(12'h4a8, 8'h00);
        rdchk(12'h4a0, 8'h00);
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wdat);
            rdchk(rows[i].adr, rows[i].rexp);
            settle();
            check(32'(drv_o), 32'(rows[i].dexp));
            check(32'(fdet_o), 32'(rows[i].fexp));
        end
        wb(12'h0a8, 1'b1, 8'h11, 1'b0, rd);
        rdchk(12'h0a8, 8'h48);
        $display("test register rows done");
        foreach (tgts[i]) begin
            wr(12'h4a4, {tgts[i], 4'h0});
            if (i == 3) begin
                @(posedge clk_i);
                tx_en_i <= 1'b1;
                repeat (3) @(posedge clk_i);
            end
            cal_run();
            check(32'(busy_n >= 2 && busy_n <= CAL_CYC), 32'h1);
            if (i == 0) check(busy_n, CAL_CYC / `RFDT_CAL_STEPS);
            check(32'(first_code), 32'h0);
            settle();
            check(32'(drv_o.timing_code), 32'(codes[i]));
            wb(12'h4ac, 1'b0, 8'h00, 1'b1, r0);
            check(32'(r0[3:0]), 32'h0);
            if (codes[i] != 3'h4) check(32'(r0[7:4] >= tgts[i]), 32'h1);
            wr(12'h4ac, 8'hff);
            rdchk(12'h4ac, r0[7:0]);
            @(posedge clk_i);
            tx_en_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            #1;
            check(32'(drv_o.timing_code), 32'(codes[i]));
            wr(12'h4a4, {tgts[i], 4'h9});
            settle();
            check(32'(drv_o.timing_code), 32'h1);
            wr(12'h4a4, {tgts[i], 4'h0});
            settle();
            check(32'(drv_o.timing_code), 32'(codes[i]));
        end
        $display("test calibration done");
        @(posedge clk_i);
        slow <= 1'b1;
        wr(12'h4a4, 8'h50);
        cal_run();
        check(32'(busy_n >= 2 && busy_n <= CAL_CYC), 32'h1);
        $display("test slow driver done");
        // reset in mid-run brings back the reset settings and an idle calibrator
        @(posedge clk_i);
        tx_en_i <= 1'b0;
        rst_i   <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check(32'(drv_o), 32'h800);
        check(32'(cal_busy_o), 32'h0);
        rdchk(12'h4a4, 8'h7c);
        rdchk(12'h4ac, 8'h00);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
`default_nettype wire
